// ### src/sre_core.sv
// execution of the three return instructions with return stack and fast restore
// Operation
// - interrupt return pops stack into program counter
// - interrupt return sets one enable at Q4
// - fast flag set restores working, status, bank
// - fast flag clear leaves those registers alone
// - literal return loads literal into working register
// - literal return pops stack into program counter
// - literal return keeps latches and status flags
// - literal return opcode is 0000 1100 kkkk kkkk
// - literal return acts at Q4, then idles
// - plain return pops stack, enables untouched
// - plain return fast flag restores shadows
// - plain return without flag restores no shadows
// - pop discards top, previous entry surfaces
`timescale 1ns/1ps
`default_nettype none
module sre_core
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [sre_pkg::SRE_INSTR_W-1:0] instr_word,
    input wire logic instr_valid,
    input wire logic irq_level_high,
    input wire logic push_req,
    input wire logic [sre_pkg::SRE_PC_W-1:0] push_addr,
    input wire logic shadow_capture,
    input wire logic irq_enable_clear,
    input wire logic working_wr_en,
    input wire logic [sre_pkg::SRE_DATA_W-1:0] working_wr_data,
    input wire logic status_wr_en,
    input wire logic [sre_pkg::SRE_DATA_W-1:0] status_wr_data,
    input wire logic bank_wr_en,
    input wire logic [sre_pkg::SRE_BANK_W-1:0] bank_wr_data,
    input wire logic latch_wr_en,
    input wire logic [sre_pkg::SRE_DATA_W-1:0] latch_high_wr_data,
    input wire logic [sre_pkg::SRE_DATA_W-1:0] latch_upper_wr_data,
    output logic instr_ready,
    output logic instr_done,
    output logic [1:0] phase,
    output logic [sre_pkg::SRE_PC_W-1:0] program_counter,
    output logic [sre_pkg::SRE_DATA_W-1:0] working_register,
    output logic [sre_pkg::SRE_DATA_W-1:0] status_register,
    output logic [sre_pkg::SRE_BANK_W-1:0] bank_select_register,
    output logic high_priority_irq_enable,
    output logic low_priority_irq_enable,
    output logic [sre_pkg::SRE_DATA_W-1:0] counter_latch_high,
    output logic [sre_pkg::SRE_DATA_W-1:0] counter_latch_upper,
    output logic [sre_pkg::SRE_PTR_W-1:0] stack_level
);
    import sre_pkg::*;

    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // sequencing
    sre_state_e state_r;
    sre_state_e state_nxt;
    sre_op_e op_r;
    sre_op_e op_nxt;
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    logic fast_r;
    logic fast_nxt;
    logic level_high_r;
    logic level_high_nxt;
    logic [SRE_DATA_W-1:0] literal_r;
    logic [SRE_DATA_W-1:0] literal_nxt;
    logic ready_nxt;
    logic done_nxt;
    logic accept;
    logic exec_q4;
    sre_op_e dec_op;

    assign dec_op = sre_decode(instr_word);
    // unknown words are not taken; the fetch side owns them
    assign accept = (state_r == SRE_IDLE) && (phase_r == SRE_PH_Q1) && instr_valid && (dec_op != SRE_OP_NONE);
    assign exec_q4 = (state_r == SRE_EXEC) && (phase_r == SRE_PH_Q4);

    always_comb
    begin
        phase_nxt = phase_r + 2'h1;
        state_nxt = state_r;
        op_nxt = op_r;
        fast_nxt = fast_r;
        level_high_nxt = level_high_r;
        literal_nxt = literal_r;
        done_nxt = 1'b0;
        unique case (state_r)
            SRE_IDLE:
            begin
                if (accept)
                begin
                    state_nxt = SRE_EXEC;
                    op_nxt = dec_op;
                    fast_nxt = instr_word[SRE_FAST_BIT];
                    level_high_nxt = irq_level_high;
                    literal_nxt = instr_word[SRE_LIT_LSB +: SRE_DATA_W];
                end
            end
            SRE_EXEC:
            begin
                if (phase_r == SRE_PH_Q4)
                    state_nxt = SRE_IDLE_CYC;
            end
            SRE_IDLE_CYC:
            begin
                if (phase_r == SRE_PH_Q4)
                begin
                    state_nxt = SRE_IDLE;
                    done_nxt = 1'b1;
                end
            end
            default:
                state_nxt = SRE_IDLE;
        endcase
        ready_nxt = (state_nxt == SRE_IDLE) && (phase_nxt == SRE_PH_Q1);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= SRE_IDLE;
            op_r <= SRE_OP_NONE;
            phase_r <= SRE_PH_Q1;
            fast_r <= 1'b0;
            level_high_r <= 1'b0;
            literal_r <= SRE_DATA_RST;
            instr_ready <= 1'b0;
            instr_done <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            phase_r <= phase_nxt;
            fast_r <= fast_nxt;
            level_high_r <= level_high_nxt;
            literal_r <= literal_nxt;
            instr_ready <= ready_nxt;
            instr_done <= done_nxt;
        end
    end
    assign phase = phase_r;

    // return stack
    logic do_pop;
    logic [SRE_PC_W-1:0] stack_top;

    assign do_pop = exec_q4;

    sre_stack u_stack
    (
        .clk(clk),
        .rst_n(rst_n),
        .push(push_req),
        .push_addr(push_addr),
        .pop(do_pop),
        .top(stack_top),
        .level(stack_level)
    );

    // architectural registers
    logic [SRE_PC_W-1:0] pc_r;
    logic [SRE_PC_W-1:0] pc_nxt;
    logic [SRE_DATA_W-1:0] w_r;
    logic [SRE_DATA_W-1:0] w_nxt;
    logic [SRE_DATA_W-1:0] st_r;
    logic [SRE_DATA_W-1:0] st_nxt;
    logic [SRE_BANK_W-1:0] bank_r;
    logic [SRE_BANK_W-1:0] bank_nxt;
    logic [SRE_DATA_W-1:0] working_shadow_r;
    logic [SRE_DATA_W-1:0] working_shadow_nxt;
    logic [SRE_DATA_W-1:0] status_shadow_r;
    logic [SRE_DATA_W-1:0] status_shadow_nxt;
    logic [SRE_BANK_W-1:0] bank_select_shadow_r;
    logic [SRE_BANK_W-1:0] bank_select_shadow_nxt;
    logic ie_high_r;
    logic ie_high_nxt;
    logic ie_low_r;
    logic ie_low_nxt;
    logic [SRE_DATA_W-1:0] lat_hi_r;
    logic [SRE_DATA_W-1:0] lat_hi_nxt;
    logic [SRE_DATA_W-1:0] lat_up_r;
    logic [SRE_DATA_W-1:0] lat_up_nxt;
    logic restore;

    assign restore = exec_q4 && fast_r && (op_r != SRE_OP_LIT_RET);

    always_comb
    begin
        pc_nxt = pc_r;
        w_nxt = working_wr_en ? working_wr_data : w_r;
        st_nxt = status_wr_en ? status_wr_data : st_r;
        bank_nxt = bank_wr_en ? bank_wr_data : bank_r;
        ie_high_nxt = irq_enable_clear ? 1'b0 : ie_high_r;
        ie_low_nxt = irq_enable_clear ? 1'b0 : ie_low_r;
        // latches written only from outside; returns never touch them
        lat_hi_nxt = latch_wr_en ? latch_high_wr_data : lat_hi_r;
        lat_up_nxt = latch_wr_en ? latch_upper_wr_data : lat_up_r;
        working_shadow_nxt = shadow_capture ? w_r : working_shadow_r;
        status_shadow_nxt = shadow_capture ? st_r : status_shadow_r;
        bank_select_shadow_nxt = shadow_capture ? bank_r : bank_select_shadow_r;
        if (exec_q4)
            pc_nxt = stack_top;
        // the executing instruction wins over a same-cycle outside write
        if (restore)
        begin
            w_nxt = working_shadow_r;
            st_nxt = status_shadow_r;
            bank_nxt = bank_select_shadow_r;
        end
        if (exec_q4 && op_r == SRE_OP_LIT_RET)
            w_nxt = literal_r;
        // setting the enable beats a same-cycle clear, so the return is not lost
        if (exec_q4 && op_r == SRE_OP_INT_RET)
        begin
            if (level_high_r)
                ie_high_nxt = 1'b1;
            else
                ie_low_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_r <= SRE_PC_RST;
            w_r <= SRE_DATA_RST;
            st_r <= SRE_DATA_RST;
            bank_r <= SRE_BANK_RST;
            working_shadow_r <= SRE_DATA_RST;
            status_shadow_r <= SRE_DATA_RST;
            bank_select_shadow_r <= SRE_BANK_RST;
            ie_high_r <= 1'b0;
            ie_low_r <= 1'b0;
            lat_hi_r <= SRE_DATA_RST;
            lat_up_r <= SRE_DATA_RST;
        end
        else
        begin
            pc_r <= pc_nxt;
            w_r <= w_nxt;
            st_r <= st_nxt;
            bank_r <= bank_nxt;
            working_shadow_r <= working_shadow_nxt;
            status_shadow_r <= status_shadow_nxt;
            bank_select_shadow_r <= bank_select_shadow_nxt;
            ie_high_r <= ie_high_nxt;
            ie_low_r <= ie_low_nxt;
            lat_hi_r <= lat_hi_nxt;
            lat_up_r <= lat_up_nxt;
        end
    end

    assign program_counter = pc_r;
    assign working_register = w_r;
    assign status_register = st_r;
    assign bank_select_register = bank_r;
    assign high_priority_irq_enable = ie_high_r;
    assign low_priority_irq_enable = ie_low_r;
    assign counter_latch_high = lat_hi_r;
    assign counter_latch_upper = lat_up_r;

    // checks
    a_pop_loads_pc:
    assert property (@(posedge clk) disable iff (!rst_n)
        exec_q4 |=> pc_r == $past(stack_top))
    else $error("program counter not loaded from stack top");

    a_irq_enable_set:
    assert property (@(posedge clk) disable iff (!rst_n)
        (accept && dec_op == SRE_OP_INT_RET) |-> ##4 (level_high_r ? ie_high_r : ie_low_r) == 1'b1)
    else $error("interrupt enable not set by interrupt return");

    a_fast_restore:
    assert property (@(posedge clk) disable iff (!rst_n)
        restore |=> w_r == $past(working_shadow_r) && st_r == $past(status_shadow_r)
            && bank_r == $past(bank_select_shadow_r))
    else $error("shadow registers not restored");

    a_no_restore_keeps:
    assert property (@(posedge clk) disable iff (!rst_n)
        (exec_q4 && !fast_r && op_r != SRE_OP_LIT_RET && !working_wr_en && !status_wr_en && !bank_wr_en)
            |=> $stable(w_r) && $stable(st_r) && $stable(bank_r))
    else $error("registers changed without fast restore");

    a_two_cycles:
    assert property (@(posedge clk) disable iff (!rst_n)
        accept |=> !instr_done [*7] ##1 instr_done)
    else $error("return did not take two instruction cycles");

    a_literal_to_working:
    assert property (@(posedge clk) disable iff (!rst_n)
        (accept && dec_op == SRE_OP_LIT_RET) |-> ##4 w_r == $past(instr_word[SRE_LIT_LSB +: SRE_DATA_W], 4))
    else $error("literal not placed in working register");

    a_latch_kept:
    assert property (@(posedge clk) disable iff (!rst_n)
        (exec_q4 && !latch_wr_en) |=> $stable(lat_hi_r) && $stable(lat_up_r))
    else $error("program counter latches changed by return");

    a_return_keeps_ie:
    assert property (@(posedge clk) disable iff (!rst_n)
        (exec_q4 && op_r != SRE_OP_INT_RET && !irq_enable_clear) |=> $stable(ie_high_r) && $stable(ie_low_r))
    else $error("interrupt enables changed by plain return");

    a_pop_level:
    assert property (@(posedge clk) disable iff (!rst_n)
        (exec_q4 && stack_level != SRE_PTR_RST) |=> stack_level == $past(stack_level) - 5'h01)
    else $error("stack level not reduced by one on pop");

    a_decode_ignored:
    assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == SRE_IDLE && dec_op == SRE_OP_NONE) |=> state_r == SRE_IDLE)
    else $error("unknown word started execution");
endmodule : sre_core
`default_nettype wire

// ### src/sre_pkg.sv
// constants, types and decode function for the return-instruction execution block
package sre_pkg;
    localparam int SRE_PC_W = 21;
    localparam int SRE_DATA_W = 8;
    localparam int SRE_BANK_W = 4;
    localparam int SRE_STACK_DEPTH = 31;
    localparam int SRE_PTR_W = 5;
    localparam int SRE_INSTR_W = 16;

    // instruction phases within one instruction cycle
    localparam logic [1:0] SRE_PH_Q1 = 2'h0;
    localparam logic [1:0] SRE_PH_Q4 = 2'h3;

    // opcode fields
    localparam logic [14:0] SRE_OPC_INT_RET = 15'h0008;
    localparam logic [14:0] SRE_OPC_RETURN = 15'h0009;
    localparam logic [7:0] SRE_OPC_LIT_RET = 8'h0C;
    localparam int SRE_FAST_BIT = 0;
    localparam int SRE_LIT_LSB = 0;

    // reset values
    localparam logic [SRE_PC_W-1:0] SRE_PC_RST = 21'h000000;
    localparam logic [SRE_DATA_W-1:0] SRE_DATA_RST = 8'h00;
    localparam logic [SRE_BANK_W-1:0] SRE_BANK_RST = 4'h0;
    localparam logic [SRE_PTR_W-1:0] SRE_PTR_RST = 5'h00;

    typedef enum logic [2:0]
    {
        SRE_IDLE = 3'b001,
        SRE_EXEC = 3'b010,
        SRE_IDLE_CYC = 3'b100
    } sre_state_e;

    typedef enum logic [1:0]
    {
        SRE_OP_NONE = 2'h0,
        SRE_OP_INT_RET = 2'h1,
        SRE_OP_RETURN = 2'h2,
        SRE_OP_LIT_RET = 2'h3
    } sre_op_e;

    function automatic sre_op_e sre_decode(input logic [SRE_INSTR_W-1:0] word);
        sre_op_e op;
        op = SRE_OP_NONE;
        if (word[15:1] == SRE_OPC_INT_RET)
            op = SRE_OP_INT_RET;
        else if (word[15:1] == SRE_OPC_RETURN)
            op = SRE_OP_RETURN;
        else if (word[15:8] == SRE_OPC_LIT_RET)
            op = SRE_OP_LIT_RET;
        return op;
    endfunction : sre_decode
endpackage : sre_pkg

// ### src/sre_stack.sv
// hardware return stack with push and pop
`timescale 1ns/1ps
`default_nettype none
module sre_stack
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic [sre_pkg::SRE_PC_W-1:0] push_addr,
    input wire logic pop,
    output logic [sre_pkg::SRE_PC_W-1:0] top,
    output logic [sre_pkg::SRE_PTR_W-1:0] level
);
    import sre_pkg::*;

    logic [SRE_PC_W-1:0] mem [0:SRE_STACK_DEPTH-1];
    logic [SRE_PTR_W-1:0] level_r;
    logic [SRE_PTR_W-1:0] level_nxt;
    logic do_push;

    // an empty stack reads as zero; popping it is ignored
    assign top = (level_r == SRE_PTR_RST) ? SRE_PC_RST : mem[level_r - 5'h01];
    assign level = level_r;
    // pop wins over a push in the same cycle; a push onto a full stack is dropped
    assign do_push = push && !pop && (level_r != 5'(SRE_STACK_DEPTH));

    always_comb
    begin
        level_nxt = level_r;
        if (pop && level_r != SRE_PTR_RST)
            level_nxt = level_r - 5'h01;
        else if (do_push)
            level_nxt = level_r + 5'h01;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            level_r <= SRE_PTR_RST;
        else
            level_r <= level_nxt;
    end

    always_ff @(posedge clk)
    begin
        if (do_push)
            mem[level_r] <= push_addr;
    end
endmodule : sre_stack
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the return-instruction execution block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sre_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic instr_valid = 1'b0, irq_level_high = 1'b0, push_req = 1'b0, shadow_capture = 1'b0;
    logic irq_enable_clear = 1'b0, working_wr_en = 1'b0, status_wr_en = 1'b0, bank_wr_en = 1'b0;
    logic latch_wr_en = 1'b0;
    logic [SRE_INSTR_W-1:0] instr_word = 16'h0000;
    logic [SRE_PC_W-1:0] push_addr = 21'h000000;
    logic [SRE_DATA_W-1:0] working_wr_data = 8'h00, status_wr_data = 8'h00;
    logic [SRE_DATA_W-1:0] latch_high_wr_data = 8'h00, latch_upper_wr_data = 8'h00;
    logic [SRE_BANK_W-1:0] bank_wr_data = 4'h0;
    logic instr_ready, instr_done, high_priority_irq_enable, low_priority_irq_enable;
    logic [1:0] phase;
    logic [SRE_PC_W-1:0] program_counter;
    logic [SRE_DATA_W-1:0] working_register, status_register, counter_latch_high, counter_latch_upper;
    logic [SRE_BANK_W-1:0] bank_select_register;
    logic [SRE_PTR_W-1:0] stack_level;
    // reference state, built from the stimulus alone
    logic [SRE_PC_W-1:0] m_pc = 21'h000000;
    logic [SRE_PC_W-1:0] stk[$];
    logic [7:0] m_w = 8'h00, m_st = 8'h00, m_sw = 8'h00, m_sst = 8'h00, m_lh = 8'h00, m_lu = 8'h00;
    logic [3:0] m_bk = 4'h0, m_sbk = 4'h0;
    logic m_hi = 1'b0, m_lo = 1'b0;
    int miscompares = 0;
    int n_compared = 0;

    sre_core i_dut
    (
        .clk, .rstn, .instr_word, .instr_valid, .irq_level_high, .push_req, .push_addr,
        .shadow_capture, .irq_enable_clear, .working_wr_en, .working_wr_data, .status_wr_en,
        .status_wr_data, .bank_wr_en, .bank_wr_data, .latch_wr_en, .latch_high_wr_data,
        .latch_upper_wr_data, .instr_ready, .instr_done, .phase, .program_counter,
        .working_register, .status_register, .bank_select_register, .high_priority_irq_enable,
        .low_priority_irq_enable, .counter_latch_high, .counter_latch_upper, .stack_level
    );

    always #12.5 clk = ~clk;

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic check_state();
        check(program_counter, m_pc);
        check(working_register, m_w);
        check(status_register, m_st);
        check(bank_select_register, m_bk);
        check(high_priority_irq_enable, m_hi);
        check(low_priority_irq_enable, m_lo);
        check(counter_latch_high, m_lh);
        check(counter_latch_upper, m_lu);
        check(stack_level, stk.size());
    endtask : check_state

    task automatic push(input logic [SRE_PC_W-1:0] a);
        push_req <= 1'b1;
        push_addr <= a;
        @(posedge clk);
        push_req <= 1'b0;
        @(posedge clk);
        stk.push_back(a);
    endtask : push

    task automatic wr_regs(input logic [7:0] w, input logic [7:0] st, input logic [3:0] bk);
        {working_wr_en, status_wr_en, bank_wr_en} <= 3'h7;
        {working_wr_data, status_wr_data, bank_wr_data} <= {w, st, bk};
        @(posedge clk);
        {working_wr_en, status_wr_en, bank_wr_en} <= 3'h0;
        latch_wr_en <= 1'b1;
        {latch_high_wr_data, latch_upper_wr_data} <= {~w, ~st};
        @(posedge clk);
        latch_wr_en <= 1'b0;
        @(posedge clk);
        {m_w, m_st, m_bk, m_lh, m_lu} = {w, st, bk, ~w, ~st};
    endtask : wr_regs

    // cap high copies into the shadows, low clears both enables
    task automatic strobe(input logic cap);
        shadow_capture <= cap;
        irq_enable_clear <= ~cap;
        @(posedge clk);
        {shadow_capture, irq_enable_clear} <= 2'h0;
        @(posedge clk);
        if (cap)
            {m_sw, m_sst, m_sbk} = {m_w, m_st, m_bk};
        else
            {m_hi, m_lo} = 2'h0;
    endtask : strobe

    // kind: 0 interrupt return, 1 plain return, 2 literal return
    task automatic exec(input logic [15:0] word, input logic lvl, input int kind);
        int i;
        int dones;
        logic taken;
        taken = 1'b0;
        dones = 0;
        instr_word <= word;
        instr_valid <= 1'b1;
        irq_level_high <= lvl;
        for (i = 0; i < 40 && !taken; i++)
        begin
            @(posedge clk);
            taken = (instr_ready === 1'b1);
        end
        instr_valid <= 1'b0;
        check(taken, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        check_state();
        check(phase, SRE_PH_Q4);
        @(posedge clk);
        #1;
        m_pc = stk.pop_back();
        if (kind == 2)
            m_w = word[7:0];
        else if (word[0])
            {m_w, m_st, m_bk} = {m_sw, m_sst, m_sbk};
        m_hi = m_hi | (kind == 0 && lvl);
        m_lo = m_lo | (kind == 0 && !lvl);
        check_state();
        for (i = 0; i < 5; i++)
        begin
            @(posedge clk);
            dones += (instr_done === 1'b1);
        end
        check(instr_done, 1'b1);
        check(dones, 1);
        check(instr_ready, 1'b1);
    endtask : exec

    task automatic t_interrupt_return();
        push(21'h1ABCD);
        push(21'h0F00E);
        wr_regs(8'h3C, 8'h5A, 4'h9);
        strobe(1'b1);
        wr_regs(8'hC3, 8'hA5, 4'h6);
        exec(16'h0011, 1'b1, 0);
        wr_regs(8'h81, 8'h42, 4'h3);
        exec(16'h0010, 1'b0, 0);
    endtask : t_interrupt_return

    task automatic t_plain_return();
        push(21'h00246);
        push(21'h1FFFE);
        strobe(1'b0);
        wr_regs(8'h77, 8'h18, 4'hE);
        exec(16'h0012, 1'b1, 1);
        exec(16'h0013, 1'b0, 1);
    endtask : t_plain_return

    task automatic t_literal_return();
        logic [7:0] lits[3];
        lits = '{8'h00, 8'hA5, 8'hFF};
        foreach (lits[i])
        begin
            push(21'h10000 | lits[i]);
            wr_regs(~lits[i], 8'h6C, 4'h5);
            exec({8'h0C, lits[i]}, 1'b1, 2);
        end
    endtask : t_literal_return

    // words close to the return codes must leave everything alone
    task automatic t_refused();
        logic [15:0] bad[4];
        bad = '{16'h0014, 16'h0D55, 16'h1C00, 16'h0000};
        push(21'h0ACE1);
        foreach (bad[i])
        begin
            instr_word <= bad[i];
            instr_valid <= 1'b1;
            repeat (12)
            begin
                @(posedge clk);
                check(instr_done, 1'b0);
            end
            instr_valid <= 1'b0;
            @(posedge clk);
            #1;
            check_state();
            @(posedge clk);
        end
    endtask : t_refused

    initial
    begin
        repeat (2000) @(posedge clk);
        miscompares++;
        $display("ERROR at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        check_state();
        @(posedge clk);
        t_interrupt_return();
        t_plain_return();
        t_literal_return();
        t_refused();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
